/* test/hbd_bridge_monitor.sv */
// Checker of the H-bridge control outputs
`timescale 1ns/100ps
`default_nettype none
module hbd_bridge_monitor
	import hbd_pkg::*;
(
	input wire logic      clk,
	input wire logic      rst_b,
	input wire logic      ahead_cmd_in,
	input wire logic      backward_cmd_in,
	input wire logic      hs_node_a_switch,
	input wire logic      ls_node_a_switch,
	input wire logic      hs_node_b_switch,
	input wire logic      ls_node_b_switch,
	input wire logic      bridge_node_a_out,
	input wire logic      bridge_node_a_oe_b,
	input wire logic      bridge_node_b_out,
	input wire logic      bridge_node_b_oe_b,
	input wire logic      circuits_active,
	input wire hbd_mode_t mode_state
);
	logic [3:0]  sw;
	logic [12:0] low_ff;
	logic [12:0] off_ff;
	logic        last_a_ff;
	assign sw = {hs_node_a_switch, ls_node_a_switch, hs_node_b_switch,
		ls_node_b_switch};
	// Saturating run lengths, so long idle spells never wrap
	// Brake ends the forward current path, so it clears the last side
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			low_ff    <= '0;
			off_ff    <= '0;
			last_a_ff <= 1'b0;
		end else begin
			low_ff <= (ahead_cmd_in || backward_cmd_in) ? '0 : low_ff + 13'(~&low_ff);
			off_ff <= (sw != 4'h0) ? '0 : off_ff + 13'(~&off_ff);
			last_a_ff <= hs_node_a_switch || (last_a_ff && !hs_node_b_switch
				&& !(ls_node_a_switch && ls_node_b_switch));
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_standby_off : assert property (
		mode_state == HBD_MODE_STANDBY && $past(mode_state) == HBD_MODE_STANDBY
		|-> sw == 4'h0 && bridge_node_a_oe_b && bridge_node_b_oe_b
		&& !circuits_active) else $error("standby not idle");
	a_node_drive : assert property (
		bridge_node_a_oe_b == !(sw[3] || sw[2]) && bridge_node_a_out == sw[3]
		&& bridge_node_b_oe_b == !(sw[1] || sw[0]) && bridge_node_b_out == sw[1]
		&& !(sw[3] && sw[2]) && !(sw[1] && sw[0]))
		else $error("node drive wrong");
	a_brake_lows : assert property (
		mode_state == HBD_MODE_BRAKE && $past(mode_state) == HBD_MODE_BRAKE
		|-> sw == 4'h5 && circuits_active) else $error("brake wrong");
	a_fwd_paths : assert property (
		mode_state == HBD_MODE_FORWARD && $past(mode_state) == HBD_MODE_FORWARD
		|-> !sw[2] && !sw[1] && circuits_active) else $error("forward wrong");
	a_rev_paths : assert property (
		mode_state == HBD_MODE_REVERSE && $past(mode_state) == HBD_MODE_REVERSE
		|-> !sw[3] && !sw[0] && circuits_active) else $error("reverse wrong");
	a_brake_quick : assert property (
		mode_state == HBD_MODE_BRAKE && $past(ahead_cmd_in && backward_cmd_in)
		&& !ahead_cmd_in && !backward_cmd_in
		|-> ##2 mode_state == HBD_MODE_STANDBY && !circuits_active)
		else $error("brake exit slow");
	a_hold_min : assert property (
		mode_state == HBD_MODE_STANDBY && $past(mode_state) inside
		{HBD_MODE_FORWARD, HBD_MODE_REVERSE} |-> low_ff >= HOLD_CYC)
		else $error("hold too short");
	a_dead_gap : assert property (
		$rose(hs_node_b_switch) && last_a_ff |-> off_ff >= DEAD_CYC)
		else $error("dead time short");
	a_low_chop_b : assert property (
		(!ahead_cmd_in) [*4] |-> !ls_node_b_switch) else $error("node b low on");
	a_low_chop_a : assert property (
		(!backward_cmd_in) [*4] |-> !ls_node_a_switch) else $error("node a low on");
endmodule : hbd_bridge_monitor
`default_nettype wire

/* test/hbd_host_model.sv */
// Host model driving direction levels and the speed pulse train
`timescale 1ns/100ps
`default_nettype none
module hbd_host_model #(
	parameter int unsigned PER = 1000
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [1:0] dir,
	input  wire logic       chop,
	input  wire logic [9:0] hi_cyc,
	output var  logic       ahead_cmd_in = 1'b0,
	output var  logic       backward_cmd_in = 1'b0
);
	logic [9:0] cnt_ff;
	logic       on;
	// 1000 cycles gives 25 kHz, well inside the legal band
	assign on = !chop || (cnt_ff < hi_cyc);
	always @(posedge clk) begin
		cnt_ff <= (!rst_b || cnt_ff >= 10'(PER - 1)) ? 10'h0 : cnt_ff + 10'h1;
		ahead_cmd_in <= rst_b && dir[1] && on;
		backward_cmd_in <= rst_b && dir[0] && on;
	end
endmodule : hbd_host_model
`default_nettype wire

/* test/test_hbd_bridge_ctrl.sv */
// Self-checking bench of the H-bridge control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
$display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end
module test_hbd_bridge_ctrl
	import hbd_pkg::*;
;
	logic       clk, rst_b, chop, ahead_cmd_in, backward_cmd_in;
	logic       hs_node_a_switch, ls_node_a_switch, circuits_active;
	logic       hs_node_b_switch, ls_node_b_switch;
	logic       bridge_node_a_out, bridge_node_a_oe_b;
	logic       bridge_node_b_out, bridge_node_b_oe_b;
	logic [1:0] dir;
	logic [9:0] hi_cyc;
	logic [7:0] ref_level, supply_level;
	logic [3:0] sw;
	hbd_mode_t  mode_state;
	int         errors, total_checks, k;
	hbd_mode_t  mode_of [4] = '{HBD_MODE_STANDBY, HBD_MODE_REVERSE,
		HBD_MODE_FORWARD, HBD_MODE_BRAKE};
	logic [3:0] sw_of [4] = '{4'h0, 4'h6, 4'h9, 4'h5};
	logic [1:0] seq [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
	assign sw = {hs_node_a_switch, ls_node_a_switch, hs_node_b_switch,
		ls_node_b_switch};
	hbd_bridge_ctrl hbd_bridge_ctrl_inst (
		.clk                (clk),
		.rst_b              (rst_b),
		.ahead_cmd_in       (ahead_cmd_in),
		.backward_cmd_in    (backward_cmd_in),
		.ref_level          (ref_level),
		.supply_level       (supply_level),
		.hs_node_a_switch   (hs_node_a_switch),
		.ls_node_a_switch   (ls_node_a_switch),
		.hs_node_b_switch   (hs_node_b_switch),
		.ls_node_b_switch   (ls_node_b_switch),
		.bridge_node_a_out  (bridge_node_a_out),
		.bridge_node_a_oe_b (bridge_node_a_oe_b),
		.bridge_node_b_out  (bridge_node_b_out),
		.bridge_node_b_oe_b (bridge_node_b_oe_b),
		.circuits_active    (circuits_active),
		.mode_state         (mode_state)
	);
	hbd_host_model hbd_host_model_inst (.clk(clk), .rst_b(rst_b), .dir(dir),
		.chop(chop), .hi_cyc(hi_cyc), .ahead_cmd_in(ahead_cmd_in),
		.backward_cmd_in(backward_cmd_in));
	// On cycles in one oscillator period, rounded up; reference below supply
	function automatic int exp_duty(int r, int s);
		return (r * OSC_CYC + s - 1) / s;
	endfunction : exp_duty
	task automatic go(input logic [1:0] d, input logic c, input int n);
		@(posedge clk);
		dir <= d;
		chop <= c;
		repeat (n) @(posedge clk);
	endtask : go
	task automatic count(input logic sel, input int n);
		k = 0;
		repeat (n) begin
			@(posedge clk);
			k += sel ? ls_node_a_switch : ls_node_b_switch;
		end
	endtask : count
	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_of_test
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		end_of_test();
	end
	initial begin
		void'($urandom(47051));
		{rst_b, chop, dir, hi_cyc} = '0;
		ref_level = 8'hC8;
		supply_level = 8'hC8;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			ref_level <= 8'($urandom);
			go(2'h0, 0, 8);
			`CHK({sw, bridge_node_a_oe_b, bridge_node_b_oe_b}, 6'h03);
		end
		ref_level <= 8'hC8;
		for (int i = 0; i < 4; i++) begin
			go(seq[i], 0, seq[i] == 2'h0 ? 8 : 120);
			`CHK(mode_state, mode_of[seq[i]]);
			`CHK(sw, sw_of[seq[i]]);
			`CHK(circuits_active, seq[i] != 2'h0);
			if (seq[i] == 2'h2) begin
				count(0, 2 * OSC_CYC);
				`CHK(k, 2 * OSC_CYC);
			end
		end
		go(2'h2, 0, 200);
		go(2'h0, 0, 100);
		go(2'h2, 0, 10);
		`CHK(mode_state, HBD_MODE_FORWARD);
		go(2'h0, 0, 3000);
		`CHK(circuits_active, 1'b1);
		repeat (200) @(posedge clk);
		`CHK(mode_state, HBD_MODE_STANDBY);
		`CHK(circuits_active, 1'b0);
		go(2'h2, 0, 100);
		for (int i = 0; i < 4; i++) begin
			ref_level <= i == 0 ? 8'h01 : i == 1 ? 8'hC7 : 8'(8 + $urandom % 190);
			supply_level <= 8'(200 + 16 * i);
			repeat (OSC_CYC + 10) @(posedge clk);
			count(0, OSC_CYC);
			`CHK(k, exp_duty(ref_level, supply_level));
		end
		ref_level <= 8'hFF;
		for (int i = 0; i < 4; i++) begin
			hi_cyc <= i == 0 ? 10'h3E7 : i == 2 ? 10'h001 : 10'(100 + $urandom % 800);
			go(i < 2 ? 2'h2 : 2'h1, 1, 1100);
			count(i >= 2, 1000);
			`CHK(k, int'(hi_cyc));
			`CHK({hs_node_a_switch, hs_node_b_switch}, i < 2 ? 2'h2 : 2'h1);
		end
		end_of_test();
	end
endmodule : test_hbd_bridge_ctrl
bind hbd_bridge_ctrl hbd_bridge_monitor hbd_bridge_monitor_inst (
	.clk                (clk),
	.rst_b              (rst_b),
	.ahead_cmd_in       (ahead_cmd_in),
	.backward_cmd_in    (backward_cmd_in),
	.hs_node_a_switch   (hs_node_a_switch),
	.ls_node_a_switch   (ls_node_a_switch),
	.hs_node_b_switch   (hs_node_b_switch),
	.ls_node_b_switch   (ls_node_b_switch),
	.bridge_node_a_out  (bridge_node_a_out),
	.bridge_node_a_oe_b (bridge_node_a_oe_b),
	.bridge_node_b_out  (bridge_node_b_out),
	.bridge_node_b_oe_b (bridge_node_b_oe_b),
	.circuits_active    (circuits_active),
	.mode_state         (mode_state)
);
`default_nettype wire

/* verilog/hbd_bridge_ctrl.sv */
// H-bridge mode decoder, shutdown hold-off, dead time and switch drive
// Behaviour
// - Both direction inputs low: standby, all switches off, outputs open.
// - Forward: node A high switch and node B low switch on.
// - Reverse: node B high switch and node A low switch on.
// - Both inputs high: brake on both low switches, circuits stay active.
// - Standby also powers down the internal circuits.
// - Standby from non-brake mode keeps previous mode at least 125us.
// - Reference mode duty equals reference level over supply level.
// - Reference equal to supply gives 100% duty, no switching.
// - PWM forward: node A high on, node B low follows pulses.
// - PWM reverse: node B high on, node A low follows pulses.
// - Low-side switching duty follows the input pulse duty.
// - About 3us dead time with switches off on current reversal.
// - Internal oscillator runs at about 26.5kHz in reference mode.
`default_nettype none
`timescale 1ns/100ps
module hbd_bridge_ctrl
	import hbd_pkg::*;
#(
	parameter int unsigned LW = LEVEL_W
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          ahead_cmd_in,
	input  wire logic          backward_cmd_in,
	input  wire logic [LW-1:0] ref_level,
	input  wire logic [LW-1:0] supply_level,
	output logic               hs_node_a_switch,
	output logic               ls_node_a_switch,
	output logic               hs_node_b_switch,
	output logic               ls_node_b_switch,
	output logic               bridge_node_a_out,
	output logic               bridge_node_a_oe_b,
	output logic               bridge_node_b_out,
	output logic               bridge_node_b_oe_b,
	output logic               circuits_active,
	output hbd_mode_t          mode_state
);

	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYC);
	localparam logic [HOLD_W-1:0] HOLD_ONE  = HOLD_W'(1);
	localparam logic [DEAD_W-1:0] DEAD_LOAD = DEAD_W'(DEAD_CYC);
	localparam logic [DEAD_W-1:0] DEAD_ONE  = DEAD_W'(1);

	// Sampled direction inputs
	logic ahead_ff;
	logic backward_ff;

	// Mode, hold-off and dead-time state
	hbd_mode_t         mode_ff;
	hbd_mode_t         nxt_mode;
	hbd_mode_t         cmd_mode;
	logic [HOLD_W-1:0] hold_cnt_ff;
	logic [HOLD_W-1:0] nxt_hold_cnt;
	logic [DEAD_W-1:0] dead_cnt_ff;
	logic [DEAD_W-1:0] nxt_dead_cnt;
	logic              active_ff;
	logic              nxt_active;

	// Switch drive
	logic hs_a_ff;
	logic ls_a_ff;
	logic hs_b_ff;
	logic ls_b_ff;
	logic nxt_hs_a;
	logic nxt_ls_a;
	logic nxt_hs_b;
	logic nxt_ls_b;

	logic duty_on;
	logic reversal;
	logic in_dead;
	logic cmd_on;

	hbd_duty_gen #(
		.PERIOD_CYC (OSC_CYC),
		.LW         (LW),
		.CW         (OSC_W)
	) u_duty (
		.clk          (clk),
		.rst_b        (rst_b),
		.run          (active_ff),
		.ref_level    (ref_level),
		.supply_level (supply_level),
		.duty_on      (duty_on)
	);

	// Input sampling: exactly one mode decoded per cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ahead_ff    <= 1'b0;
			backward_ff <= 1'b0;
		end else begin
			ahead_ff    <= ahead_cmd_in;
			backward_ff <= backward_cmd_in;
		end
	end

	always_comb begin
		case ({ahead_ff, backward_ff})
			2'b10:   cmd_mode = HBD_MODE_FORWARD;
			2'b01:   cmd_mode = HBD_MODE_REVERSE;
			2'b11:   cmd_mode = HBD_MODE_BRAKE;
			default: cmd_mode = HBD_MODE_STANDBY;
		endcase
	end

	// Mode sequencing
	always_comb begin
		nxt_mode     = mode_ff;
		nxt_hold_cnt = HOLD_RST;
		nxt_dead_cnt = (dead_cnt_ff != DEAD_RST) ?
			dead_cnt_ff - DEAD_ONE : DEAD_RST;
		reversal =
			(mode_ff == HBD_MODE_FORWARD && cmd_mode == HBD_MODE_REVERSE) ||
			(mode_ff == HBD_MODE_REVERSE && cmd_mode == HBD_MODE_FORWARD);
		case (cmd_mode)
			HBD_MODE_STANDBY: begin
				case (mode_ff)
					HBD_MODE_FORWARD,
					HBD_MODE_REVERSE: begin
						// Short low phases of a pulse train never
						// reach shutdown
						if (hold_cnt_ff >= HOLD_LAST) begin
							nxt_mode = HBD_MODE_STANDBY;
						end else begin
							nxt_hold_cnt = hold_cnt_ff + HOLD_ONE;
						end
					end
					default: begin
						nxt_mode = HBD_MODE_STANDBY;
					end
				endcase
			end
			HBD_MODE_FORWARD,
			HBD_MODE_REVERSE: begin
				nxt_mode = cmd_mode;
				if (reversal) begin
					nxt_dead_cnt = DEAD_LOAD;
				end
			end
			HBD_MODE_BRAKE: begin
				nxt_mode = HBD_MODE_BRAKE;
			end
			default: begin
				nxt_mode = HBD_MODE_STANDBY;
			end
		endcase
		nxt_active = nxt_mode != HBD_MODE_STANDBY;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			mode_ff     <= HBD_MODE_STANDBY;
			hold_cnt_ff <= HOLD_RST;
			dead_cnt_ff <= DEAD_RST;
			active_ff   <= 1'b0;
		end else begin
			mode_ff     <= nxt_mode;
			hold_cnt_ff <= nxt_hold_cnt;
			dead_cnt_ff <= nxt_dead_cnt;
			active_ff   <= nxt_active;
		end
	end

	// Switch drive
	always_comb begin
		nxt_hs_a = 1'b0;
		nxt_ls_a = 1'b0;
		nxt_hs_b = 1'b0;
		nxt_ls_b = 1'b0;
		in_dead  = dead_cnt_ff != DEAD_RST;
		// Input still high selects the low side; low during hold-off
		// is the off phase of an input pulse
		cmd_on   = cmd_mode == mode_ff;
		case (mode_ff)
			HBD_MODE_FORWARD: begin
				if (!in_dead) begin
					nxt_hs_a = 1'b1;
					nxt_ls_b = cmd_on && duty_on;
				end
			end
			HBD_MODE_REVERSE: begin
				if (!in_dead) begin
					nxt_hs_b = 1'b1;
					nxt_ls_a = cmd_on && duty_on;
				end
			end
			HBD_MODE_BRAKE: begin
				nxt_ls_a = 1'b1;
				nxt_ls_b = 1'b1;
			end
			default: begin
				// All off, nodes left open
				nxt_hs_a = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hs_a_ff <= 1'b0;
			ls_a_ff <= 1'b0;
			hs_b_ff <= 1'b0;
			ls_b_ff <= 1'b0;
		end else begin
			hs_a_ff <= nxt_hs_a;
			ls_a_ff <= nxt_ls_a;
			hs_b_ff <= nxt_hs_b;
			ls_b_ff <= nxt_ls_b;
		end
	end

	assign hs_node_a_switch   = hs_a_ff;
	assign ls_node_a_switch   = ls_a_ff;
	assign hs_node_b_switch   = hs_b_ff;
	assign ls_node_b_switch   = ls_b_ff;
	// Node driven only while one of its switches conducts
	assign bridge_node_a_out  = hs_a_ff;
	assign bridge_node_a_oe_b = !(hs_a_ff || ls_a_ff);
	assign bridge_node_b_out  = hs_b_ff;
	assign bridge_node_b_oe_b = !(hs_b_ff || ls_b_ff);
	assign circuits_active    = active_ff;
	assign mode_state         = mode_ff;

endmodule : hbd_bridge_ctrl
`default_nettype wire

/* verilog/hbd_duty_gen.sv */
// Internal PWM oscillator with reference-to-supply duty compare
`default_nettype none
`timescale 1ns/100ps
module hbd_duty_gen
	import hbd_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = OSC_CYC,
	parameter int unsigned LW         = LEVEL_W,
	parameter int unsigned CW         = OSC_W
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          run,
	input  wire logic [LW-1:0] ref_level,
	input  wire logic [LW-1:0] supply_level,
	output logic               duty_on
);

	localparam int unsigned PW = LW + CW;
	localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
	localparam logic [CW-1:0] ONE  = CW'(1);
	localparam logic [CW-1:0] PER  = CW'(PERIOD_CYC);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	logic          duty_ff;
	logic          nxt_duty;
	logic [PW-1:0] phase_prod;
	logic [PW-1:0] ref_prod;

	assign duty_on = duty_ff;

	always_comb begin
		phase_prod = PW'(cnt_ff) * PW'(supply_level);
		ref_prod   = PW'(ref_level) * PW'(PER);
		// Stopped oscillator in standby saves power
		if (!run) begin
			nxt_cnt = OSC_RST;
		end else if (cnt_ff >= LAST) begin
			nxt_cnt = OSC_RST;
		end else begin
			nxt_cnt = cnt_ff + ONE;
		end
		// Reference at or above supply keeps the drive on: no chopping
		nxt_duty = phase_prod < ref_prod;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_ff  <= OSC_RST;
			duty_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			duty_ff <= nxt_duty;
		end
	end

endmodule : hbd_duty_gen
`default_nettype wire

/* verilog/hbd_pkg.sv */
// Shared constants and types for the H-bridge direction and speed control
`default_nettype none
package hbd_pkg;

	// Clock rate of the clock driving all counters
	localparam int unsigned CLK_HZ        = 25_000_000;
	localparam int unsigned CLK_PERIOD_NS = 40;

	// Dead time on current reversal, least time, rounded up
	localparam int unsigned DEAD_NS  = 3000;
	localparam int unsigned DEAD_CYC =
		(DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Shutdown hold-off after both direction inputs fall, least time
	localparam int unsigned HOLD_US  = 125;
	localparam int unsigned HOLD_CYC =
		(HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Internal PWM oscillator, 26.5 kHz in units of 100 Hz
	localparam int unsigned OSC_HZ_X100 = 265;
	localparam int unsigned OSC_CYC     = CLK_HZ / (OSC_HZ_X100 * 100);

	// Counter widths
	localparam int unsigned DEAD_W = $clog2(DEAD_CYC + 1);
	localparam int unsigned HOLD_W = $clog2(HOLD_CYC + 1);
	localparam int unsigned OSC_W  = $clog2(OSC_CYC + 1);

	// Width of the digitised reference and supply levels
	localparam int unsigned LEVEL_W = 8;

	// Counter reset values
	localparam logic [DEAD_W-1:0] DEAD_RST = '0;
	localparam logic [HOLD_W-1:0] HOLD_RST = '0;
	localparam logic [OSC_W-1:0]  OSC_RST  = '0;

	typedef enum logic [2:0] {
		HBD_MODE_STANDBY,
		HBD_MODE_FORWARD,
		HBD_MODE_REVERSE,
		HBD_MODE_BRAKE
	} hbd_mode_t;

endpackage : hbd_pkg
`default_nettype wire
